// file: design/scim_top.sv
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "scim_consts.svh"
// How it works
// - A one written to a bit of irq_enable_set sets that source's mask bit; a zero leaves it.
// - A one written to a bit of irq_enable_clear clears that mask bit; a zero leaves it.
// - Reading irq_mask_view returns one for each enabled source and zero for each disabled one.
// - Bits 0 to 7 are tx ready, tx empty, tx end, tx counters zero, rx ready, overrun, rx end, rx counters zero.
// - The transmit counters zero condition has its own enable, disable and mask bit.
// - The receive overrun condition has its own enable, disable and mask bit.
// - Compare 0 and compare 1 matches each have their own enable, disable and mask bit.
// - Transmit sync and receive sync are separate sources and disable-register bits clear them.
// - The receive counters zero condition has its own enable, disable and mask bit.
// - The compare flags set on a match and hold until the next status read.
// - The overrun flag sets when a word is loaded over an unread one and clears on status read.
// - The transmit empty flag is one only once the holding register and shifter are both empty.
// - The sync flags set on their events and hold until the next status read.
module scim_top
  import scim_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tx_holding_free,
  input wire logic tx_shift_busy,
  input wire logic tx_transfer_done,
  input wire logic tx_counters_zero,
  input wire logic rx_word_available,
  input wire logic rx_load,
  input wire logic rx_transfer_done,
  input wire logic rx_counters_zero,
  input wire logic compare_zero_match,
  input wire logic compare_one_match,
  input wire logic tx_sync_event,
  input wire logic rx_sync_event,
  output logic irq
);
  scim_if link (.clk(clk), .rst_b(rst_b));

  logic ap_wr_q;
  scim_reg_e ap_reg_q;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic irq_q;
  logic hreadyout_q;
  logic hresp_q;
  logic accept;
  logic rd_accept;
  scim_reg_e addr_reg;
  scim_src_t mask_fwd;

  // Maps a byte offset onto one of the four word registers; anything else is unmapped.
  function automatic scim_reg_e scim_decode(input logic [31:0] addr);
    logic [11:0] ofs;
    ofs = addr[11:0];
    if (addr[31:12] != 20'h00000) begin
      scim_decode = SCIM_R_NONE;
    end else if (ofs == `SCIM_OFS_STATUS) begin
      scim_decode = SCIM_R_STATUS;
    end else if (ofs == `SCIM_OFS_EN_SET) begin
      scim_decode = SCIM_R_EN_SET;
    end else if (ofs == `SCIM_OFS_EN_CLR) begin
      scim_decode = SCIM_R_EN_CLR;
    end else if (ofs == `SCIM_OFS_MASK) begin
      scim_decode = SCIM_R_MASK;
    end else begin
      scim_decode = SCIM_R_NONE;
    end
  endfunction

  assign accept = hsel && htrans[1] && hready;
  assign rd_accept = accept && !hwrite;
  assign addr_reg = scim_decode(haddr);

  // Writes land at the end of the data phase, when hwdata stands.
  assign link.set_we = ap_wr_q && (ap_reg_q == SCIM_R_EN_SET);
  assign link.clr_we = ap_wr_q && (ap_reg_q == SCIM_R_EN_CLR);
  assign link.wbits = hwdata[`SCIM_NUM_SRC-1:0];
  // A status read clears the sticky flags at the edge that samples the read data.
  assign link.stat_rd = rd_accept && (addr_reg == SCIM_R_STATUS);

  // A read that follows a mask write back to back sees the write's result.
  assign mask_fwd = (link.mask | (link.set_we ? link.wbits : 12'h000)) &
                    ~(link.clr_we ? link.wbits : 12'h000);

  assign hrdata_d = (addr_reg == SCIM_R_MASK) ? {20'h00000, mask_fwd} :
                    (addr_reg == SCIM_R_STATUS) ? {20'h00000, link.status} :
                    32'h00000000;

  scim_mask u_mask (
    .bus(link)
  );

  scim_status u_status (
    .bus(link),
    .tx_holding_free(tx_holding_free),
    .tx_shift_busy(tx_shift_busy),
    .tx_transfer_done(tx_transfer_done),
    .tx_counters_zero(tx_counters_zero),
    .rx_word_available(rx_word_available),
    .rx_load(rx_load),
    .rx_transfer_done(rx_transfer_done),
    .rx_counters_zero(rx_counters_zero),
    .compare_zero_match(compare_zero_match),
    .compare_one_match(compare_one_match),
    .tx_sync_event(tx_sync_event),
    .rx_sync_event(rx_sync_event)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ap_wr_q <= 1'b0;
      ap_reg_q <= SCIM_R_NONE;
    end else if (hready) begin
      ap_wr_q <= accept && hwrite;
      ap_reg_q <= accept ? addr_reg : SCIM_R_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_accept) begin
      hrdata_q <= hrdata_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
      hreadyout_q <= 1'b1;
      hresp_q <= `SCIM_HRESP_OKAY;
    end else begin
      irq_q <= |(link.status & link.mask);
      hreadyout_q <= 1'b1;
      hresp_q <= `SCIM_HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_set_write;
    link.set_we;
  endsequence

  sequence s_clr_write;
    link.clr_we;
  endsequence

  sequence s_mask_read;
    rd_accept && (addr_reg == SCIM_R_MASK);
  endsequence

  sequence s_status_read;
    link.stat_rd;
  endsequence

  a_set_ones_enable: assert property (s_set_write |=>
    ((link.mask & $past(link.wbits)) == $past(link.wbits)))
    else $error("Enable write did not set the mask bits written as one.");

  a_set_zeros_keep: assert property (s_set_write |=>
    ((link.mask & ~$past(link.wbits)) == ($past(link.mask) & ~$past(link.wbits))))
    else $error("Enable write changed mask bits written as zero.");

  a_clr_ones_disable: assert property (s_clr_write |=>
    ((link.mask & $past(link.wbits)) == 12'h000))
    else $error("Disable write did not clear the mask bits written as one.");

  a_clr_zeros_keep: assert property (s_clr_write |=>
    ((link.mask & ~$past(link.wbits)) == ($past(link.mask) & ~$past(link.wbits))))
    else $error("Disable write changed mask bits written as zero.");

  a_mask_view_read: assert property (s_mask_read |=>
    (hrdata == {20'h00000, link.mask}))
    else $error("Mask view read does not match the mask.");

  a_sync_disable: assert property (s_clr_write ##0 link.wbits[`SCIM_B_RX_SYNC] |=>
    !link.mask[`SCIM_B_RX_SYNC])
    else $error("Receive sync disable did not clear its mask bit.");

  a_upper_zero: assert property (s_status_read or s_mask_read |=>
    (hrdata[31:12] == 20'h00000))
    else $error("Unused read bits are not zero.");

  a_irq_raise: assert property (((link.status & link.mask) != 12'h000) |=> irq)
    else $error("Interrupt missing for an enabled flag.");

  a_irq_quiet: assert property (((link.status & link.mask) == 12'h000) |=> !irq)
    else $error("Interrupt raised with no enabled flag.");

  a_mask_reset: assert property ($rose(rst_b) |-> (link.mask == 12'h000))
    else $error("Mask not zero after reset.");

  a_compare_hold: assert property (link.status[`SCIM_B_COMPARE_ZERO] && !link.stat_rd
    |=> link.status[`SCIM_B_COMPARE_ZERO])
    else $error("Compare 0 flag dropped without a status read.");

  a_compare_set_wins: assert property (s_status_read ##0 compare_one_match
    |=> link.status[`SCIM_B_COMPARE_ONE])
    else $error("Compare 1 match lost to a status read.");

  a_overrun_set: assert property (rx_load && rx_word_available
    |=> link.status[`SCIM_B_RX_OVERRUN_FLAG])
    else $error("Overrun flag not set on a load over an unread word.");

  a_overrun_clear: assert property (s_status_read ##0 !(rx_load && rx_word_available)
    |=> !link.status[`SCIM_B_RX_OVERRUN_FLAG])
    else $error("Overrun flag survived a status read.");

  a_tx_empty: assert property (link.status[`SCIM_B_TX_ALL_SENT]
    |-> (tx_holding_free && !tx_shift_busy))
    else $error("Transmit empty shown while data remains.");

  a_sync_clear: assert property (s_status_read ##0 !tx_sync_event
    |=> !link.status[`SCIM_B_TX_SYNC] [*1])
    else $error("Transmit sync flag survived a status read.");

  sequence s_unmapped_read;
    rd_accept && (addr_reg == SCIM_R_NONE);
  endsequence

  a_enable_exclusive: assert property (s_set_write |->
    !link.clr_we)
    else $error("Enable and disable writes fell in one cycle.");

  a_mask_idle_stable: assert property (!link.set_we && !link.clr_we |=>
    $stable(link.mask))
    else $error("Mask changed without an enable or disable write.");

  a_unmapped_read_zero: assert property (s_unmapped_read |=>
    (hrdata == 32'h00000000))
    else $error("Unmapped read returned nonzero data.");

  a_wo_read_zero: assert property (
    rd_accept && ((addr_reg == SCIM_R_EN_SET) || (addr_reg == SCIM_R_EN_CLR))
    |=> (hrdata == 32'h00000000))
    else $error("Read of a write-only register returned nonzero data.");

  a_status_view_read: assert property (s_status_read |=>
    (hrdata == {20'h00000, $past(link.status)}))
    else $error("Status read does not match the flags.");

  a_read_data_hold: assert property (!rd_accept |=>
    $stable(hrdata))
    else $error("Read data changed without a read.");

  a_cmp0_set: assert property (compare_zero_match |=>
    link.status[`SCIM_B_COMPARE_ZERO])
    else $error("Compare 0 match did not set its flag.");

  a_cmp1_set: assert property (compare_one_match |=>
    link.status[`SCIM_B_COMPARE_ONE])
    else $error("Compare 1 match did not set its flag.");

  a_txsync_set: assert property (tx_sync_event |=>
    link.status[`SCIM_B_TX_SYNC])
    else $error("Transmit sync event did not set its flag.");

  a_rxsync_set: assert property (rx_sync_event |=>
    link.status[`SCIM_B_RX_SYNC])
    else $error("Receive sync event did not set its flag.");

  a_cmp1_hold: assert property (!link.stat_rd &&
    link.status[`SCIM_B_COMPARE_ONE] |=> link.status[`SCIM_B_COMPARE_ONE])
    else $error("Compare 1 flag dropped without a status read.");

  a_txsync_hold: assert property (!link.stat_rd &&
    link.status[`SCIM_B_TX_SYNC] |=> link.status[`SCIM_B_TX_SYNC])
    else $error("Transmit sync flag dropped without a status read.");

  a_rxsync_hold: assert property (!link.stat_rd &&
    link.status[`SCIM_B_RX_SYNC] |=> link.status[`SCIM_B_RX_SYNC])
    else $error("Receive sync flag dropped without a status read.");

  a_overrun_hold: assert property (!link.stat_rd &&
    link.status[`SCIM_B_RX_OVERRUN_FLAG] |=> link.status[`SCIM_B_RX_OVERRUN_FLAG])
    else $error("Overrun flag dropped without a status read.");

  a_cmp0_clear: assert property (s_status_read ##0 !compare_zero_match |=>
    !link.status[`SCIM_B_COMPARE_ZERO])
    else $error("Compare 0 flag survived a status read.");

  a_rxsync_clear: assert property (s_status_read ##0 !rx_sync_event |=>
    !link.status[`SCIM_B_RX_SYNC])
    else $error("Receive sync flag survived a status read.");

  a_cmp0_no_spurious: assert property (!compare_zero_match &&
    !link.status[`SCIM_B_COMPARE_ZERO] |=> !link.status[`SCIM_B_COMPARE_ZERO])
    else $error("Compare 0 flag set without a match.");

  a_overrun_no_spurious: assert property (!(rx_load && rx_word_available) &&
    !link.status[`SCIM_B_RX_OVERRUN_FLAG] |=> !link.status[`SCIM_B_RX_OVERRUN_FLAG])
    else $error("Overrun flag set without a load over an unread word.");

  a_tx_levels: assert property (
    (link.status[`SCIM_B_TX_HOLDING_FREE] == tx_holding_free) &&
    (link.status[`SCIM_B_TX_COUNTERS_ZERO] == tx_counters_zero))
    else $error("Transmit level flags do not follow their inputs.");

  a_rx_levels: assert property (
    (link.status[`SCIM_B_RX_WORD_AVAILABLE] == rx_word_available) &&
    (link.status[`SCIM_B_RX_COUNTERS_ZERO] == rx_counters_zero))
    else $error("Receive level flags do not follow their inputs.");

  a_done_levels: assert property (
    (link.status[`SCIM_B_TX_TRANSFER_DONE] == tx_transfer_done) &&
    (link.status[`SCIM_B_RX_TRANSFER_DONE] == rx_transfer_done))
    else $error("Transfer done flags do not follow their inputs.");

  a_tx_empty_set: assert property (tx_holding_free && !tx_shift_busy |->
    link.status[`SCIM_B_TX_ALL_SENT])
    else $error("Transmit empty missing although all data is sent.");

  a_txzero_enable: assert property (s_set_write ##0
    link.wbits[`SCIM_B_TX_COUNTERS_ZERO] |=> link.mask[`SCIM_B_TX_COUNTERS_ZERO])
    else $error("Transmit counters zero enable did not set its mask bit.");

  a_overrun_disable: assert property (s_clr_write ##0
    link.wbits[`SCIM_B_RX_OVERRUN_FLAG] |=> !link.mask[`SCIM_B_RX_OVERRUN_FLAG])
    else $error("Overrun disable did not clear its mask bit.");

  a_cmp1_enable: assert property (s_set_write ##0
    link.wbits[`SCIM_B_COMPARE_ONE] |=> link.mask[`SCIM_B_COMPARE_ONE])
    else $error("Compare 1 enable did not set its mask bit.");

  a_rxzero_disable: assert property (s_clr_write ##0
    link.wbits[`SCIM_B_RX_COUNTERS_ZERO] |=> !link.mask[`SCIM_B_RX_COUNTERS_ZERO])
    else $error("Receive counters zero disable did not clear its mask bit.");

  a_txsync_disable: assert property (s_clr_write ##0
    link.wbits[`SCIM_B_TX_SYNC] |=> !link.mask[`SCIM_B_TX_SYNC])
    else $error("Transmit sync disable did not clear its mask bit.");

  a_bus_okay: assert property (hreadyout && (hresp == `SCIM_HRESP_OKAY))
    else $error("Slave inserted a wait state or an error response.");
endmodule

// file: design/scim_consts.svh
`ifndef SCIM_CONSTS_SVH
`define SCIM_CONSTS_SVH

`define SCIM_OFS_STATUS 12'h000
`define SCIM_OFS_EN_SET 12'h004
`define SCIM_OFS_EN_CLR 12'h008
`define SCIM_OFS_MASK 12'h00C

`define SCIM_NUM_SRC 12
`define SCIM_MASK_RST 12'h000
`define SCIM_HRESP_OKAY 1'b0

`define SCIM_B_TX_HOLDING_FREE 0
`define SCIM_B_TX_ALL_SENT 1
`define SCIM_B_TX_TRANSFER_DONE 2
`define SCIM_B_TX_COUNTERS_ZERO 3
`define SCIM_B_RX_WORD_AVAILABLE 4
`define SCIM_B_RX_OVERRUN_FLAG 5
`define SCIM_B_RX_TRANSFER_DONE 6
`define SCIM_B_RX_COUNTERS_ZERO 7
`define SCIM_B_COMPARE_ZERO 8
`define SCIM_B_COMPARE_ONE 9
`define SCIM_B_TX_SYNC 10
`define SCIM_B_RX_SYNC 11

`endif

// file: design/scim_pkg.sv
package scim_pkg;
  typedef logic [11:0] scim_src_t;
  typedef enum logic [2:0] {
    SCIM_R_NONE = 3'b000,
    SCIM_R_STATUS = 3'b001,
    SCIM_R_EN_SET = 3'b010,
    SCIM_R_EN_CLR = 3'b011,
    SCIM_R_MASK = 3'b100
  } scim_reg_e;
endpackage

// file: design/scim_if.sv
`timescale 1ns/1ps
interface scim_if
  import scim_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b
);
  logic set_we;
  logic clr_we;
  scim_src_t wbits;
  scim_src_t mask;
  logic stat_rd;
  scim_src_t status;

  modport mask_side (input clk, rst_b, set_we, clr_we, wbits, output mask);
  modport stat_side (input clk, rst_b, stat_rd, output status);
  modport ctrl (output set_we, clr_we, wbits, stat_rd, input mask, status);
endinterface

// file: design/scim_mask.sv
`timescale 1ns/1ps
`include "scim_consts.svh"
module scim_mask
  import scim_pkg::*;
(
  scim_if.mask_side bus
);
  scim_src_t mask_q;
  scim_src_t mask_d;

  // Each bit is set by the enable register and cleared by the disable register.
  for (genvar i = 0; i < `SCIM_NUM_SRC; i++) begin : g_bit
    assign mask_d[i] = (bus.set_we && bus.wbits[i]) ? 1'b1 :
                       (bus.clr_we && bus.wbits[i]) ? 1'b0 :
                       mask_q[i];
  end

  always_ff @(posedge bus.clk) begin
    if (!bus.rst_b) begin
      mask_q <= `SCIM_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  assign bus.mask = mask_q;
endmodule

// file: design/scim_status.sv
`timescale 1ns/1ps
`include "scim_consts.svh"
module scim_status
  import scim_pkg::*;
(
  scim_if.stat_side bus,
  input wire logic tx_holding_free,
  input wire logic tx_shift_busy,
  input wire logic tx_transfer_done,
  input wire logic tx_counters_zero,
  input wire logic rx_word_available,
  input wire logic rx_load,
  input wire logic rx_transfer_done,
  input wire logic rx_counters_zero,
  input wire logic compare_zero_match,
  input wire logic compare_one_match,
  input wire logic tx_sync_event,
  input wire logic rx_sync_event
);
  logic [4:0] sticky_q;
  logic [4:0] sticky_d;
  logic [4:0] sticky_ev;

  // A new word loaded while the previous one is still unread is an overrun.
  assign sticky_ev = {rx_sync_event, tx_sync_event, compare_one_match, compare_zero_match,
                      rx_load && rx_word_available};
  // An event in the cycle of a status read survives the read's clear.
  assign sticky_d = sticky_ev | (sticky_q & {5{~bus.stat_rd}});

  always_ff @(posedge bus.clk) begin
    if (!bus.rst_b) begin
      sticky_q <= 5'h00;
    end else begin
      sticky_q <= sticky_d;
    end
  end

  assign bus.status = {sticky_q[4:1], rx_counters_zero, rx_transfer_done, sticky_q[0],
                       rx_word_available, tx_counters_zero, tx_transfer_done,
                       tx_holding_free && !tx_shift_busy,
                       tx_holding_free};
endmodule

// file: dv/tb_serial_ctrl_irq_mask.sv
`timescale 1ns/1ps
`include "scim_consts.svh"
module tb_serial_ctrl_irq_mask
  import scim_pkg::*;
;
  localparam logic [31:0] A_ST = {20'h0, `SCIM_OFS_STATUS};
  localparam logic [31:0] A_SET = {20'h0, `SCIM_OFS_EN_SET};
  localparam logic [31:0] A_CLR = {20'h0, `SCIM_OFS_EN_CLR};
  localparam logic [31:0] A_MSK = {20'h0, `SCIM_OFS_MASK};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic busy = 1'b0;
  logic rx_load = 1'b0;
  logic [7:0] lv = 8'h00;
  logic [3:0] ev = 4'h0;
  logic [31:0] lfsr = 32'h51;
  logic [31:0] d;
  logic [31:0] r;
  scim_src_t m = 12'h000;
  int n_errors = 0;
  int comparisons = 0;

  always #4 clk = ~clk;

  scim_top u_dut (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_holding_free(lv[0]), .tx_shift_busy(busy), .tx_transfer_done(lv[2]),
    .tx_counters_zero(lv[3]), .rx_word_available(lv[4]), .rx_load(rx_load),
    .rx_transfer_done(lv[6]), .rx_counters_zero(lv[7]),
    .compare_zero_match(ev[0]), .compare_one_match(ev[1]),
    .tx_sync_event(ev[2]), .rx_sync_event(ev[3]), .irq(irq)
  );

  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // Level part of the status word; the sticky bits 5 and 8 to 11 are left zero.
  function logic [31:0] st_exp(logic [7:0] l, logic b);
    logic [31:0] v;
    v = {24'h0, l};
    v[1] = l[0] & ~b;
    v[5] = 1'b0;
    return v;
  endfunction

  task final_report();
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      n_errors++;
      final_report();
    end
  endtask

  task ahb(logic wr, logic [31:0] a, logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
    check("hreadyout", {31'h0, hreadyout}, 32'h1);
  endtask

  task wr(logic [31:0] a, logic [31:0] wd);
    logic [31:0] x;
    ahb(1'b1, a, wd, x);
  endtask

  task rd_chk(string nm, logic [31:0] a, logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    check(nm, x, exp);
  endtask

  task pulse_ev(int k);
    ev <= 4'h1 << k;
    @(posedge clk);
    ev <= 4'h0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_chk("mask_reset", A_MSK, 32'h0);
    check("irq_reset", {31'h0, irq}, 32'h0);
    for (int i = 0; i < 12; i++) begin
      wr(A_SET, 32'h1 << i);
      wr(A_SET, 32'hFFFFF000);
      rd_chk("mask_one", A_MSK, 32'h1 << i);
      wr(A_CLR, 32'h1 << i);
      rd_chk("mask_clear", A_MSK, 32'h0);
    end
    wr(32'h0000_0010, 32'h0000_0FFF);
    rd_chk("unmapped", 32'h0000_0010, 32'h0);
    rd_chk("set_reads_zero", A_SET, 32'h0);
    wr(A_MSK, 32'h0000_0FFF);
    wr(A_ST, 32'h0000_0FFF);
    rd_chk("mask_after_unmapped", A_MSK, 32'h0);
    for (int i = 0; i < 40; i++) begin
      d = rnd();
      r = rnd();
      if (d[31]) begin
        wr(A_SET, d);
        m = m | d[11:0];
      end else begin
        wr(A_CLR, d);
        m = m & ~d[11:0];
      end
      lv <= r[7:0] & 8'hDF;
      busy <= r[8];
      rd_chk("mask_rand", A_MSK, {20'h0, m});
      repeat (2) @(posedge clk);
      check("irq_level", {31'h0, irq}, {31'h0, |(st_exp(lv, busy) & {20'h0, m})});
      rd_chk("status_level", A_ST, st_exp(lv, busy));
    end
    wr(A_CLR, 32'h0000_0FFF);
    lv <= 8'h00;
    busy <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(A_SET, 32'h100 << k);
      pulse_ev(k);
      check("irq_event", {31'h0, irq}, 32'h1);
      rd_chk("status_event", A_ST, 32'h100 << k);
      repeat (3) @(posedge clk);
      check("irq_after_read", {31'h0, irq}, 32'h0);
      rd_chk("status_cleared", A_ST, 32'h0);
      wr(A_CLR, 32'h100 << k);
      pulse_ev(k);
      check("irq_masked", {31'h0, irq}, 32'h0);
      rd_chk("status_masked", A_ST, 32'h100 << k);
    end
    ev <= 4'h2;
    fork
      rd_chk("status_race", A_ST, 32'h0);
      begin
        @(posedge clk);
        ev <= 4'h0;
      end
    join
    rd_chk("status_race_kept", A_ST, 32'h200);
    wr(A_SET, 32'h0000_0020);
    rx_load <= 1'b1;
    @(posedge clk);
    rx_load <= 1'b0;
    lv <= 8'h10;
    repeat (3) @(posedge clk);
    rd_chk("no_overrun", A_ST, 32'h10);
    check("irq_no_overrun", {31'h0, irq}, 32'h0);
    rx_load <= 1'b1;
    @(posedge clk);
    rx_load <= 1'b0;
    repeat (3) @(posedge clk);
    check("irq_overrun", {31'h0, irq}, 32'h1);
    rd_chk("status_overrun", A_ST, 32'h30);
    rd_chk("overrun_cleared", A_ST, 32'h10);
    wr(A_SET, 32'h0000_0FFF);
    repeat (2) @(posedge clk);
    check("irq_all", {31'h0, irq}, 32'h1);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    check("irq_in_reset", {31'h0, irq}, 32'h0);
    check("hrdata_in_reset", hrdata, 32'h0);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_chk("mask_rereset", A_MSK, 32'h0);
    final_report();
  end
endmodule
